// ==== include/rtm_consts.svh ====
// Constants of the receive stream TLP mapper
`ifndef RTM_CONSTS_SVH
`define RTM_CONSTS_SVH

`define RTM_READY_LATENCY  2
`define RTM_DW_W           32
`define RTM_FMT_DATA_BIT   30
`define RTM_FMT_4DW_BIT    29
`define RTM_TYPE_MSG_HI    28
`define RTM_TYPE_MSG_LO    27
`define RTM_TYPE_MSG_CODE  2'h2
`define RTM_ADDR_QW_BIT    2
`define RTM_HDR_3DW        3'h3
`define RTM_HDR_4DW        3'h4
`define RTM_UPPER_QW_LANE  3'h2
`define RTM_LANES_64       4'h2
`define RTM_LANES_128      4'h4

`endif

// ==== include/rtm_pkg.sv ====
// Types shared by the receive stream TLP mapper
package rtm_pkg;

	typedef struct packed {
		logic first;
		logic last;
		logic void_hi;
		logic err;
	} rtm_mark_t;

endpackage

// ==== core/rtm_ready_delay.sv ====
// Ready latency pipeline for the receive stream
`timescale 1ns/1ps
`default_nettype none

module rtm_ready_delay #(
	parameter int LAT = 2
) (
	input  wire logic           sys_clk_in,
	input  wire logic           rstn_in,
	input  wire logic           ready_in,
	output logic  [LAT:1]       tap_out
);

	// One register holds every stage so each bit has a single driver
	logic [LAT:1] stage_ff;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stage_ff <= '0;
		end else begin
			stage_ff[1] <= ready_in;
			for (int i = 2; i <= LAT; i++) begin
				stage_ff[i] <= stage_ff[i-1];
			end
		end
	end

	assign tap_out = stage_ff;

endmodule

`default_nettype wire

// ==== core/rtm_rx_mapper.sv ====
// Receive stream TLP mapper: header/payload byte order, qword alignment, beat framing
//
// Overview of operation
// - Header dwords pass in wire order, byte 0 in the top byte lane.
// - Payload dwords have their bytes reversed, byte 4n lowest.
// - Message TLPs are framed as four-dword headers.
// - Payload stays address aligned even when header address is meaningless.
// - Payload aligned to qwords; misaligned start shifts it into the upper dword.
// - Request payload position taken from request address bit 2.
// - Completion payload position from lower address bit 2.
// - Lanes before a misaligned start carry no data; receiver ignores them.
// - Address translation bits are never checked; no malformed flag raised.
// - Stream width is a fixed 64 or 128 bit instance choice.
// - First marker only on the first beat, meaningful with valid.
// - Last marker only on the final beat, meaningful with valid.
// - 128-bit mode flags a void upper qword; unused at 64 bits.
// - Valid on cycle n+2 only if ready was high on cycle n.
// - First payload dword lane depends on address qword alignment.
// - Valid drops within two clocks of ready falling, resumes within two.
// - Uncorrectable error flag held with valid; packet may end early.
`timescale 1ns/1ps
`default_nettype none
`include "rtm_consts.svh"

module rtm_rx_mapper
	import rtm_pkg::*;
#(
	parameter int DATA_W = 128
) (
	input  wire logic                sys_clk_in,
	input  wire logic                rstn_in,
	input  wire logic [31:0]         tlp_dword_in,
	input  wire logic                tlp_valid_in,
	input  wire logic                tlp_last_in,
	input  wire logic                tlp_err_in,
	output logic                     tlp_ready_out,
	input  wire logic                rx_sink_ready_in,
	output logic [DATA_W-1:0]        rx_stream_payload_out,
	output logic                     rx_beat_valid_out,
	output logic                     rx_packet_first_out,
	output logic                     rx_packet_last_out,
	output logic                     rx_upper_qword_void_out,
	output logic                     rx_uncorrectable_flag_out
);

	localparam logic [3:0] LANES = 4'(DATA_W / `RTM_DW_W);
	localparam bit         WIDE  = (LANES == `RTM_LANES_128);

	////////////////////////////////////////////////////////////////////////////

	function automatic logic [31:0] swap_bytes(input logic [31:0] d);
		swap_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction

	// Messages always take the four-dword framing
	function automatic logic [2:0] hdr_len(input logic [31:0] d);
		if (d[`RTM_FMT_4DW_BIT] ||
			d[`RTM_TYPE_MSG_HI:`RTM_TYPE_MSG_LO] == `RTM_TYPE_MSG_CODE) begin
			hdr_len = `RTM_HDR_4DW;
		end else begin
			hdr_len = `RTM_HDR_3DW;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////

	logic [`RTM_READY_LATENCY-1:1] rdy_tap;

	// Output register supplies the last stage of the ready latency
	rtm_ready_delay #(
		.LAT        (`RTM_READY_LATENCY - 1)
	) u_ready_delay (
		.sys_clk_in (sys_clk_in),
		.rstn_in    (rstn_in),
		.ready_in   (rx_sink_ready_in),
		.tap_out    (rdy_tap)
	);

	logic              rdy_now;
	logic              rdy_soon;
	assign rdy_now  = rdy_tap[`RTM_READY_LATENCY-1];
	// Ready seen now frees the beat one edge later; exact for a latency of two
	assign rdy_soon = rx_sink_ready_in;

	logic [DATA_W-1:0] beat_ff;
	logic [DATA_W-1:0] nxt_beat;
	rtm_mark_t         mark_ff;
	rtm_mark_t         nxt_mark;
	logic              full_ff;
	logic              nxt_full;
	logic [1:0]        lane_ff;
	logic [1:0]        nxt_lane;
	logic [2:0]        hidx_ff;
	logic [2:0]        hlen_ff;
	logic              data_ff;
	logic              drop_ff;
	logic              tlp_ready_ff;

	logic              acc;
	logic              pop;
	logic              is_dw0;
	logic              is_hdr;
	logic              is_hlast;
	logic              has_data;
	logic              ending;
	logic              skip;
	logic [2:0]        cur_len;
	logic [2:0]        pos;
	logic [31:0]       wr_dw;

	// Beat pops one clock after ready was seen; valid shows on the clock after that
	assign pop = full_ff && rdy_now;
	assign acc = tlp_valid_in && tlp_ready_ff;

	always_comb begin
		is_dw0   = (hidx_ff == 3'h0);
		cur_len  = is_dw0 ? hdr_len(tlp_dword_in) : hlen_ff;
		has_data = is_dw0 ? tlp_dword_in[`RTM_FMT_DATA_BIT] : data_ff;
		is_hdr   = (hidx_ff < cur_len);
		is_hlast = is_hdr && ((hidx_ff + 3'h1) == cur_len);
		ending   = tlp_last_in || tlp_err_in;
		// Address bit 2 sits in the last header dword for requests and completions;
		// AT bits are passed through untouched
		skip     = is_hlast && has_data && !ending &&
			(((3'({1'b0, lane_ff}) + 3'h1) & 3'h1) != 3'({2'b0, tlp_dword_in[`RTM_ADDR_QW_BIT]}));
		pos      = 3'({1'b0, lane_ff}) + 3'h1 + 3'({2'b0, skip});
		wr_dw    = is_hdr ? tlp_dword_in : swap_bytes(tlp_dword_in);
		// Cleared on pop so skipped lanes hold zero
		nxt_beat = pop ? '0 : beat_ff;
		nxt_mark = pop ? '0 : mark_ff;
		nxt_full = full_ff && !pop;
		nxt_lane = lane_ff;
		if (acc && !drop_ff) begin
			nxt_beat[lane_ff*`RTM_DW_W +: `RTM_DW_W] = wr_dw;
			nxt_mark.first = nxt_mark.first || is_dw0;
			nxt_mark.err   = nxt_mark.err || tlp_err_in;
			if (ending) begin
				nxt_mark.last    = 1'b1;
				nxt_mark.void_hi = WIDE && (3'({1'b0, lane_ff}) < `RTM_UPPER_QW_LANE);
				nxt_full         = 1'b1;
				nxt_lane         = 2'h0;
			end else if (pos >= 3'(LANES)) begin
				nxt_full = 1'b1;
				nxt_lane = 2'(pos - 3'(LANES));
			end else begin
				nxt_lane = 2'(pos);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			beat_ff <= '0;
			mark_ff <= '0;
			full_ff <= 1'b0;
			lane_ff <= 2'h0;
		end else begin
			beat_ff <= nxt_beat;
			mark_ff <= nxt_mark;
			full_ff <= nxt_full;
			lane_ff <= nxt_lane;
		end
	end

	// Taking a word while full is safe only because the pop is already certain
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tlp_ready_ff <= 1'b0;
		end else begin
			tlp_ready_ff <= !nxt_full || rdy_soon;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hidx_ff <= 3'h0;
			hlen_ff <= `RTM_HDR_3DW;
			data_ff <= 1'b0;
			drop_ff <= 1'b0;
		end else if (acc) begin
			if (ending) begin
				hidx_ff <= 3'h0;
			end else if (is_hdr && !drop_ff) begin
				hidx_ff <= hidx_ff + 3'h1;
			end
			if (is_dw0 && !drop_ff) begin
				hlen_ff <= cur_len;
				data_ff <= has_data;
			end
			// Error ends the packet early; rest of the TLP is discarded
			drop_ff <= tlp_err_in ? !tlp_last_in : (drop_ff && !tlp_last_in);
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_beat_valid_out         <= 1'b0;
			rx_stream_payload_out     <= '0;
			rx_packet_first_out       <= 1'b0;
			rx_packet_last_out        <= 1'b0;
			rx_upper_qword_void_out   <= 1'b0;
			rx_uncorrectable_flag_out <= 1'b0;
		end else begin
			rx_beat_valid_out <= pop;
			if (pop) begin
				rx_stream_payload_out     <= beat_ff;
				rx_packet_first_out       <= mark_ff.first;
				rx_packet_last_out        <= mark_ff.last;
				rx_upper_qword_void_out   <= mark_ff.void_hi;
				rx_uncorrectable_flag_out <= mark_ff.err;
			end else begin
				rx_packet_first_out       <= 1'b0;
				rx_packet_last_out        <= 1'b0;
				rx_upper_qword_void_out   <= 1'b0;
				rx_uncorrectable_flag_out <= 1'b0;
			end
		end
	end

	assign tlp_ready_out = tlp_ready_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checking helpers

	logic [31:0] hdr0_ff;
	logic        in_pkt_ff;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hdr0_ff   <= '0;
			in_pkt_ff <= 1'b0;
		end else begin
			if (acc && is_dw0 && !drop_ff) begin
				hdr0_ff <= tlp_dword_in;
			end
			if (rx_beat_valid_out) begin
				in_pkt_ff <= !rx_packet_last_out;
			end
		end
	end

	chk_valid_latency: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		rx_beat_valid_out |-> $past(rx_sink_ready_in, `RTM_READY_LATENCY))
		else $error("valid without ready two cycles before");

	chk_valid_drops: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		!rx_sink_ready_in |-> ##`RTM_READY_LATENCY !rx_beat_valid_out)
		else $error("valid not dropped after ready fell");

	chk_first_only_start: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(rx_beat_valid_out && in_pkt_ff) |-> !rx_packet_first_out)
		else $error("first marker inside a packet");

	chk_last_in_packet: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(rx_beat_valid_out && rx_packet_last_out) |-> (in_pkt_ff || rx_packet_first_out))
		else $error("last marker outside a packet");

	chk_void_width: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		rx_upper_qword_void_out |-> (WIDE && rx_beat_valid_out && rx_packet_last_out))
		else $error("void flag on wrong beat or width");

	chk_err_with_valid: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		rx_uncorrectable_flag_out |-> (rx_beat_valid_out && rx_packet_last_out))
		else $error("error flag without valid last beat");

	chk_header_order: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(pop && mark_ff.first) |=> (rx_stream_payload_out[31:0] == $past(hdr0_ff)))
		else $error("header dword 0 misplaced");

	chk_payload_swap: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(acc && !drop_ff && !is_hdr && lane_ff == 2'h0)
		|=> (beat_ff[31:0] == swap_bytes($past(tlp_dword_in))))
		else $error("payload byte order wrong");

	chk_qword_align: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(acc && !drop_ff && is_hlast && has_data && !ending)
		|=> (lane_ff[0] == $past(tlp_dword_in[`RTM_ADDR_QW_BIT])))
		else $error("payload not qword aligned");

endmodule

`default_nettype wire

// ==== dv/rtm_app_sink.sv ====
// Application-side sink model for the receive stream
`timescale 1ns/1ps
`default_nettype none

module rtm_app_sink
	import rtm_pkg::*;
#(
	parameter int DATA_W = 64
) (
	input  wire logic              sys_clk_in,
	input  wire logic              rstn_in,
	input  wire logic              stall_in,
	output logic                   ready_out,
	input  wire logic              valid_in,
	input  wire logic [DATA_W-1:0] data_in,
	input  wire rtm_mark_t         mark_in
);
	logic [DATA_W-1:0] dq[$];
	rtm_mark_t         mq[$];

	////////////////////////////////////////////////////////////////////////////////
	// Throttle on command; registered like real consumer logic
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ready_out <= 1'b0;
		end else begin
			ready_out <= !stall_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Beats recorded only with valid; idle cycles carry nothing
	always @(posedge sys_clk_in) begin
		if (rstn_in && valid_in) begin
			dq.push_back(data_in);
			mq.push_back(mark_in);
		end
	end
endmodule

`default_nettype wire

// ==== dv/test_pcie_rx_stream_tlp_mapper.sv ====
// Self-checking bench of the receive stream TLP mapper, 64- and 128-bit instances
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp=%h got=%h", nm, e, g); end end

module test_pcie_rx_stream_tlp_mapper;
	import rtm_pkg::*;
	logic        sys_clk_in;
	logic        rstn_in;
	logic        stall;
	logic [31:0] dw;
	logic        dv;
	logic        dl;
	logic        de;
	wire logic   tr;
	wire logic   sr;
	wire logic   bv;
	wire logic   pf;
	wire logic   pl;
	wire logic   uv;
	wire logic   uf;
	wire logic [63:0] pd;
	wire logic [127:0] pdw;
	wire logic [3:0]   mkw;
	wire logic         trw;
	wire logic         srw;
	wire logic         bvw;
	logic              wide;
	wire rtm_mark_t   mk = {pf, pl, uv, uf};
	int          n_errors;
	int          checked;
	// MWr with nonzero AT bits, CfgWr, IOWr, CplD
	logic [31:0] tbl[4] = '{32'h4000_0C01, 32'h4400_0001, 32'h4200_0001, 32'h4A00_0001};
	localparam logic [63:0] ALL = 64'hFFFF_FFFF_FFFF_FFFF;

	rtm_rx_mapper #(.DATA_W(64)) dut_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.tlp_dword_in(dw), .tlp_valid_in(dv && !wide), .tlp_last_in(dl), .tlp_err_in(de),
		.tlp_ready_out(tr), .rx_sink_ready_in(sr), .rx_stream_payload_out(pd),
		.rx_beat_valid_out(bv), .rx_packet_first_out(pf), .rx_packet_last_out(pl),
		.rx_upper_qword_void_out(uv), .rx_uncorrectable_flag_out(uf));

	rtm_app_sink #(.DATA_W(64)) app_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.stall_in(stall), .ready_out(sr), .valid_in(bv), .data_in(pd), .mark_in(mk));

	// Wide instance takes the same dword stream while wide is set
	rtm_rx_mapper #(.DATA_W(128)) dut_w (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.tlp_dword_in(dw), .tlp_valid_in(dv && wide), .tlp_last_in(dl), .tlp_err_in(de),
		.tlp_ready_out(trw), .rx_sink_ready_in(srw), .rx_stream_payload_out(pdw),
		.rx_beat_valid_out(bvw), .rx_packet_first_out(mkw[3]), .rx_packet_last_out(mkw[2]),
		.rx_upper_qword_void_out(mkw[1]), .rx_uncorrectable_flag_out(mkw[0]));

	rtm_app_sink #(.DATA_W(128)) appw_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.stall_in(stall), .ready_out(srw), .valid_in(bvw), .data_in(pdw), .mark_in(mkw));

	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] sw(input logic [31:0] x);
		return {x[7:0], x[15:8], x[23:16], x[31:24]};
	endfunction

	task automatic send(input logic [31:0] d[$], input int ei);
		for (int i = 0; i < d.size(); i++) begin
			dw <= d[i];
			dv <= 1'b1;
			dl <= (i == d.size() - 1);
			de <= (i == ei);
			@(posedge sys_clk_in);
			while ((wide ? trw : tr) !== 1'b1) @(posedge sys_clk_in);
		end
		dv <= 1'b0;
		dl <= 1'b0;
		de <= 1'b0;
	endtask

	// Bounded wait; extra cycles catch stray beats
	task automatic wait_beats(input int n);
		int k;
		k = 0;
		while (app_u.dq.size() < n && k < 200) begin
			@(posedge sys_clk_in);
			k++;
		end
		repeat (6) @(posedge sys_clk_in);
		`CHK("beat count", n, app_u.dq.size())
	endtask

	task automatic beat(input int i, input logic [63:0] e, input logic [63:0] m,
		input logic [3:0] mark);
		`CHK("beat data", e & m, app_u.dq[i] & m)
		`CHK("beat marks", mark, app_u.mq[i])
	endtask

	task automatic clr();
		app_u.dq.delete();
		app_u.mq.delete();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_req3(input logic [31:0] h0);
		logic [31:0] d[$];
		d = '{h0, 32'h0000_000F, 32'h0000_1004, 32'h1122_3344};
		clr();
		send(d, -1);
		wait_beats(2);
		beat(0, {d[1], d[0]}, ALL, 4'h8);
		beat(1, {sw(d[3]), d[2]}, ALL, 4'h4);
	endtask

	// Aligned address: skip pushes payload to next beat lane 0
	task automatic t_mis();
		logic [31:0] d[$];
		d = '{32'h4000_0002, 32'h0000_000F, 32'h0000_1000, 32'hA1B2_C3D4, 32'h0102_0304};
		clr();
		send(d, -1);
		wait_beats(3);
		beat(1, {32'h0, d[2]}, 64'h0000_0000_FFFF_FFFF, 4'h0);
		beat(2, {sw(d[4]), sw(d[3])}, ALL, 4'h4);
	endtask

	// Message with data: four-dword header, payload still placed by bit 2
	task automatic t_msg();
		logic [31:0] d[$];
		d = '{32'h7000_0001, 32'h0000_00FF, 32'h1234_5678, 32'h0000_0004, 32'hCAFE_F00D};
		clr();
		send(d, -1);
		wait_beats(3);
		beat(1, {d[3], d[2]}, ALL, 4'h0);
		beat(2, {sw(d[4]), 32'h0}, 64'hFFFF_FFFF_0000_0000, 4'h4);
	endtask

	// 128-bit: skip closes the beat; a lone data dword leaves the upper qword void
	task automatic t_wide();
		logic [31:0] d[$];
		d = '{32'h4000_0001, 32'h0000_000F, 32'h0000_1000, 32'h1122_3344};
		wide <= 1'b1;
		appw_u.dq.delete();
		appw_u.mq.delete();
		send(d, -1);
		@(posedge sys_clk_in);
		d[2] = 32'h0000_1004;
		send(d, -1);
		repeat (12) @(posedge sys_clk_in);
		wide <= 1'b0;
		`CHK("wide beats", 3, appw_u.dq.size())
		`CHK("wide beat 0", 96'h0000_1000_0000_000F_4000_0001, appw_u.dq[0][95:0])
		`CHK("wide marks 0", 4'h8, appw_u.mq[0])
		`CHK("wide beat 1", 32'h4433_2211, appw_u.dq[1][31:0])
		`CHK("wide marks 1", 4'h6, appw_u.mq[1])
		`CHK("wide beat 2", 128'h4433_2211_0000_1004_0000_000F_4000_0001, appw_u.dq[2])
		`CHK("wide marks 2", 4'hC, appw_u.mq[2])
	endtask

	task automatic t_thr();
		logic [31:0] d[$];
		d = '{32'h4000_0001, 32'h0000_000F, 32'h0000_1004, 32'h5566_7788};
		stall <= 1'b1;
		clr();
		repeat (4) @(posedge sys_clk_in);
		fork
			send(d, -1);
		join_none
		repeat (30) @(posedge sys_clk_in);
		`CHK("beats while throttled", 0, app_u.dq.size())
		stall <= 1'b0;
		wait_beats(2);
		wait fork;
		beat(1, {sw(d[3]), d[2]}, ALL, 4'h4);
	endtask

	// Error on the first payload dword ends the packet on the erroring beat
	task automatic t_err();
		logic [31:0] d[$];
		d = '{32'h4000_0004, 32'h0000_000F, 32'h0000_1004, 32'h1, 32'h2, 32'h3, 32'h4};
		clr();
		send(d, 3);
		wait_beats(2);
		beat(1, {sw(d[3]), d[2]}, ALL, 4'h5);
	endtask

	task automatic conclude();
		$display("errors=%0d checks=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rstn_in = 1'b0;
		stall = 1'b0;
		wide = 1'b0;
		dw = 32'h0;
		dv = 1'b0;
		dl = 1'b0;
		de = 1'b0;
		n_errors = 0;
		checked = 0;
		repeat (16) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		t_err();
		foreach (tbl[i]) t_req3(tbl[i]);
		t_mis();
		t_msg();
		t_wide();
		t_thr();
		conclude();
	end

	// Whole run needs well under a few thousand cycles
	initial begin
		#80000;
		n_errors++;
		conclude();
	end
endmodule

`default_nettype wire
